// ---- hdl/smb_ctrl.sv ----
// two-wire serial controller: flags, shift data byte, master and slave engines
`timescale 1ns/10ps
`include "smb_params.svh"
module smb_ctrl #(
   parameter logic [15:0] HALF_CYC = 16'(`SMB_HALF_CYC)
) (
   input  wire logic                  i_core_clk,
   input  wire logic                  i_rst,
   input  wire smb_pkg::smb_sfr_req_t i_sfr,
   output logic [7:0]                 o_sfr_rdata,
   input  wire logic                  i_scl,
   input  wire logic                  i_sda,
   output smb_pkg::smb_pin_out_t      o_pins,
   output logic                       o_irq
);
   import smb_pkg::*;

   smb_state_t r_reg;
   smb_state_t r_next;
   logic       scl;
   logic       sda;
   logic       scl_rise;
   logic       start_det;
   logic       stop_det;
   logic       done;
   logic       lose;
   logic       wr_ctrl;
   logic       wr_dat;

   ////////////////////////////////////////////////////////////////////////
   // synchronised pin view and bus condition detectors
   assign scl       = r_reg.scl_sy[1];
   assign sda       = r_reg.sda_sy[1];
   assign scl_rise  = scl & ~r_reg.scl_d;
   assign start_det = scl & r_reg.scl_d & r_reg.sda_d & ~sda;
   assign stop_det  = scl & r_reg.scl_d & ~r_reg.sda_d & sda;
   assign done      = (r_reg.cnt == HALF_CYC - 16'h0001);
   assign wr_ctrl   = i_sfr.wr & (i_sfr.addr == `SMB_CTRL_ADDR);
   assign wr_dat    = i_sfr.wr & (i_sfr.addr == `SMB_DAT_ADDR);

   // open-drain pins only ever pull low; SCL is also held low while stalled
   assign o_pins = '{scl_o: 1'b0, scl_oe: r_reg.scl_oe, sda_o: 1'b0, sda_oe: r_reg.sda_oe};
   assign o_sfr_rdata = r_reg.rdata;
   assign o_irq       = r_reg.si;

   ////////////////////////////////////////////////////////////////////////
   // next-state logic: software access first, hardware events after so sets win
   always_comb begin
      r_next        = r_reg;
      lose          = 1'b0;
      r_next.scl_sy = {r_reg.scl_sy[0], i_scl};
      r_next.sda_sy = {r_reg.sda_sy[0], i_sda};
      r_next.scl_d  = scl;
      r_next.sda_d  = sda;
      r_next.cnt    = done ? 16'h0000 : r_reg.cnt + 16'h0001; // half-bit timer, wraps at HALF_CYC-1 unless the bit engine holds it at 0

      // register port writes
      if (wr_ctrl) begin
         r_next.start_request_flag = i_sfr.wdata[`SMB_B_STA];
         r_next.stop_request_flag = i_sfr.wdata[`SMB_B_STO];
         r_next.ack = i_sfr.wdata[`SMB_B_ACK];
         if (!i_sfr.wdata[`SMB_B_SI]) begin
            r_next.si      = 1'b0;
            r_next.arbitration_lost_flag = 1'b0;
         end
      end
      if (i_sfr.wr && i_sfr.addr == `SMB_CFG_ADDR) begin
         r_next.ena = i_sfr.wdata[`SMB_B_ENA];
         r_next.inh = i_sfr.wdata[`SMB_B_INH];
      end
      if (wr_dat) begin
         r_next.dat    = i_sfr.wdata;
         r_next.dat_wr = 1'b1;
      end
      // registered read data, one cycle after the read strobe
      case (i_sfr.addr)
         `SMB_CTRL_ADDR: r_next.rdata = {r_reg.master, r_reg.transmit_direction_flag, r_reg.start_request_flag, r_reg.stop_request_flag,
                                         r_reg.ack_needed_flag, r_reg.arbitration_lost_flag, r_reg.ack, r_reg.si};
         `SMB_CFG_ADDR:  r_next.rdata = {r_reg.ena, r_reg.inh, r_reg.busy, 5'h00};
         `SMB_DAT_ADDR:  r_next.rdata = r_reg.dat;
         default:        r_next.rdata = 8'h00;
      endcase
      if (!i_sfr.rd) begin
         r_next.rdata = r_reg.rdata;
      end

      // bit engine
      case (r_reg.st)
         SMB_IDLE: begin
            r_next.scl_oe = 1'b0;
            r_next.sda_oe = 1'b0;
            r_next.cnt    = 16'h0000;
            if (r_reg.ena && r_reg.start_request_flag && !r_reg.busy) begin
               r_next.st = SMB_START;
            end
         end
         SMB_START: begin
            r_next.sda_oe = 1'b1; // SDA falls while SCL is high
            if (done) begin
               r_next.scl_oe = 1'b1;
               r_next.master = 1'b1;
               r_next.transmit_direction_flag = 1'b1;
               r_next.si     = 1'b1;
               r_next.busy   = 1'b1;
               r_next.bitn   = 4'h0;
               r_next.st     = SMB_MLOW;
            end
         end
         SMB_RSTART, SMB_STOP: begin
            // phase 0: SCL low, set SDA; phase 1: release SCL; phase 2 (stop): release SDA
            if (r_reg.bitn == 4'h0) begin
               r_next.scl_oe = 1'b1;
               r_next.sda_oe = (r_reg.st == SMB_STOP);
               if (done) begin
                  r_next.scl_oe = 1'b0;
                  r_next.bitn   = 4'h1;
               end
            end else if (r_reg.bitn == 4'h1) begin
               if (done) begin
                  if (!scl) begin
                     lose = 1'b1;
                  end else if (r_reg.st == SMB_RSTART) begin
                     r_next.st = SMB_START;
                  end else begin
                     r_next.sda_oe = 1'b0;
                     r_next.bitn   = 4'h2;
                  end
               end
            end else if (done) begin
               r_next.master = 1'b0;
               r_next.stop_request_flag    = 1'b0;
               r_next.st     = SMB_IDLE;
            end
         end
         SMB_MLOW: begin
            r_next.scl_oe = 1'b1;
            if (r_reg.si) begin
               r_next.cnt = 16'h0000;
            end else if (r_reg.bitn == 4'h9) begin
               r_next.cnt = 16'h0000;
               r_next.bitn = 4'h0;
               if (r_reg.stop_request_flag) begin
                  r_next.st = SMB_STOP;
               end else if (r_reg.start_request_flag) begin
                  r_next.st = SMB_RSTART;
               end else begin
                  r_next.transmit_direction_flag = r_reg.dat_wr;
                  r_next.dat_wr = 1'b0;
               end
            end else begin
               if (r_reg.bitn < 4'h8) begin
                  r_next.sda_oe = r_reg.transmit_direction_flag & ~r_reg.dat[7];
               end else begin
                  r_next.sda_oe = ~r_reg.transmit_direction_flag & r_reg.ack;
               end
               if (done) begin // SDA is set one cycle into the low phase and settles HALF_CYC-1 cycles before SCL rises
                  r_next.scl_oe = 1'b0;
                  r_next.dat_wr = 1'b0; // frame begun: a data write from here on is too late
                  r_next.st     = SMB_MHIGH;
               end
            end
         end
         SMB_MHIGH: begin
            if (!scl) begin
               r_next.cnt = 16'h0000; // wait out a slave stretching SCL
            end else if (done) begin
               r_next.scl_oe = 1'b1;
               r_next.st     = SMB_MLOW;
               r_next.bitn   = r_reg.bitn + 4'h1;
               if (r_reg.bitn < 4'h8) begin
                  r_next.dat = {r_reg.dat[6:0], sda};
                  if (r_reg.transmit_direction_flag && !r_reg.sda_oe && !sda) begin
                     lose = 1'b1;
                  end else if (r_reg.bitn == 4'h7 && !r_reg.transmit_direction_flag) begin
                     r_next.ack_needed_flag = 1'b1;
                     r_next.ack   = 1'b0;
                     r_next.si    = 1'b1;
                  end
               end else begin
                  r_next.ack_needed_flag  = 1'b0;
                  if (r_reg.transmit_direction_flag) begin
                     r_next.ack = ~sda;
                     r_next.si  = 1'b1;
                  end
               end
            end
         end
         SMB_SLV: begin
            r_next.scl_oe = r_reg.si;
            if (!scl) begin
               if (r_reg.bitn < 4'h8) begin
                  r_next.sda_oe = r_reg.transmit_direction_flag & ~r_reg.dat[7] & ~r_reg.si;
               end else begin
                  r_next.sda_oe = (r_reg.bitn == 4'h8) & ~r_reg.transmit_direction_flag & r_reg.ack
                                  & ~r_reg.ignore;
               end
            end
            if (!scl && r_reg.scl_d && r_reg.bitn == 4'h9) begin
               r_next.bitn   = 4'h0;
               r_next.transmit_direction_flag = r_reg.dat_wr;
               r_next.dat_wr = 1'b0;
            end
            if (scl_rise && !r_reg.si) begin
               r_next.bitn = r_reg.bitn + 4'h1;
               if (r_reg.bitn < 4'h8) begin
                  r_next.dat = {r_reg.dat[6:0], sda};
                  if (r_reg.transmit_direction_flag && !r_reg.sda_oe && !sda) begin
                     r_next.arbitration_lost_flag = 1'b1;
                     r_next.si      = 1'b1;
                     r_next.transmit_direction_flag  = 1'b0;
                  end else if (r_reg.bitn == 4'h7 && !r_reg.transmit_direction_flag) begin
                     if (r_reg.addr_ph) begin
                        r_next.start_request_flag = 1'b1;
                     end
                     if (!r_reg.ignore && !(r_reg.addr_ph && r_reg.inh)) begin
                        r_next.ack_needed_flag = 1'b1;
                        r_next.ack   = 1'b0;
                        r_next.si    = 1'b1;
                     end else begin
                        r_next.ignore = 1'b1;
                     end
                  end
               end else if (r_reg.bitn == 4'h8) begin
                  r_next.ack_needed_flag   = 1'b0;
                  r_next.addr_ph = 1'b0;
                  if (r_reg.addr_ph && !r_reg.ack) begin
                     r_next.ignore = 1'b1; // unacknowledged address: quiet until START
                  end
                  if (r_reg.transmit_direction_flag) begin
                     r_next.ack = ~sda;
                     r_next.si  = ~r_reg.ignore;
                  end
               end
            end
         end
         default: begin
            r_next.st = SMB_IDLE;
         end
      endcase

      // lost arbitration drops to slave receiver, byte kept in place
      if (lose) begin
         r_next.arbitration_lost_flag = 1'b1;
         r_next.master  = 1'b0;
         r_next.transmit_direction_flag  = 1'b0;
         r_next.si      = 1'b1;
         r_next.scl_oe  = 1'b0;
         r_next.sda_oe  = 1'b0;
         r_next.addr_ph = 1'b0;
         r_next.ignore  = 1'b0;
         r_next.st      = SMB_SLV;
      end

      // bus monitor: START and STOP seen by anyone
      if (start_det && r_reg.st != SMB_START) begin
         r_next.busy   = 1'b1;
         r_next.transmit_direction_flag = 1'b0;
         if (r_reg.master && !r_reg.start_request_flag) begin
            r_next.arbitration_lost_flag = 1'b1;
            r_next.master  = 1'b0;
            r_next.si      = 1'b1;
         end
         r_next.st      = SMB_SLV;
         r_next.bitn    = 4'h0;
         r_next.addr_ph = 1'b1;
         r_next.ignore  = 1'b0;
         r_next.dat_wr  = 1'b0;
         r_next.scl_oe  = 1'b0;
         r_next.sda_oe  = 1'b0;
      end
      if (stop_det) begin
         r_next.busy = 1'b0;
         if (r_reg.st != SMB_STOP) begin
            if (r_reg.master) begin
               r_next.arbitration_lost_flag = 1'b1;
               r_next.stop_request_flag     = 1'b1;
               r_next.si      = 1'b1;
               r_next.master  = 1'b0;
            end else if (r_reg.st == SMB_SLV && !r_reg.addr_ph && !r_reg.ignore) begin
               r_next.stop_request_flag = 1'b1;
               r_next.si  = 1'b1;
            end
            r_next.st     = SMB_IDLE;
            r_next.scl_oe = 1'b0;
            r_next.sda_oe = 1'b0;
         end
      end

      // disabled interface lets go of the bus
      if (!r_reg.ena) begin
         r_next.st     = SMB_IDLE;
         r_next.master = 1'b0;
         r_next.busy   = 1'b0;
         r_next.scl_oe = 1'b0;
         r_next.sda_oe = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         r_reg        <= '0;
         r_reg.st     <= SMB_IDLE;
         r_reg.dat    <= `SMB_DAT_RESET;
         r_reg.scl_sy <= 2'b11;
         r_reg.sda_sy <= 2'b11;
         r_reg.scl_d  <= 1'b1;
         r_reg.sda_d  <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   AST_IRQ_LEVEL: assert property (i_sfr.rd && i_sfr.addr == `SMB_CTRL_ADDR
                                   |=> o_sfr_rdata[`SMB_B_SI] == $past(o_irq))
      else $error("irq differs from interrupt flag");
   AST_SCL_STALL: assert property (r_reg.si && r_reg.master |-> ##1 o_pins.scl_oe)
      else $error("scl released while stalled as master");
   AST_DAT_STABLE: assert property (r_reg.si && !wr_dat |=> $stable(r_reg.dat) || !r_reg.si)
      else $error("data byte changed while interrupt flag set");
   AST_ARB_CLEAR: assert property ($fell(r_reg.si) |-> !r_reg.arbitration_lost_flag)
      else $error("arbitration lost flag survived interrupt clear");
   AST_START_FLAGS: assert property ($rose(r_reg.master) |-> r_reg.si && r_reg.transmit_direction_flag)
      else $error("start generated without interrupt or transmit mode");
   AST_STA_KEPT: assert property (r_reg.start_request_flag && !wr_ctrl |=> r_reg.start_request_flag)
      else $error("start flag cleared by hardware");
   AST_ACK_NEEDED_FLAG_IRQ: assert property ($rose(r_reg.ack_needed_flag) |-> r_reg.si && !r_reg.ack)
      else $error("ack request raised without interrupt or with ack preset");
   AST_STOP_DONE: assert property ($fell(r_reg.stop_request_flag) && !$past(wr_ctrl) |-> !r_reg.master)
      else $error("stop flag cleared while still master");
   AST_MSB_FIRST: assert property (r_reg.st == SMB_MHIGH && r_reg.transmit_direction_flag && r_reg.bitn < 4'h8
                                   |-> r_reg.sda_oe == ~r_reg.dat[7])
      else $error("transmitted bit is not the data msb");
endmodule

// ---- inc/smb_params.svh ----
// constants for the two-wire serial flag and data controller
`ifndef SMB_PARAMS_SVH
`define SMB_PARAMS_SVH
`define SMB_CTRL_ADDR 8'hc0
`define SMB_CFG_ADDR  8'hc1
`define SMB_DAT_ADDR  8'hc2
`define SMB_DAT_RESET 8'h00
`define SMB_B_STA     5
`define SMB_B_STO     4
`define SMB_B_ACK     1
`define SMB_B_SI      0
`define SMB_B_ENA     7
`define SMB_B_INH     6
`define SMB_HALF_NS   5000
`define SMB_CLK_MHZ   100
`define SMB_HALF_CYC  ((`SMB_HALF_NS * `SMB_CLK_MHZ) / 1000)
`endif

// ---- inc/smb_pkg.sv ----
// types shared by the two-wire serial flag and data controller
package smb_pkg;
   typedef enum logic [2:0] {
      SMB_IDLE   = 3'b000,
      SMB_START  = 3'b001,
      SMB_MLOW   = 3'b010,
      SMB_MHIGH  = 3'b011,
      SMB_STOP   = 3'b100,
      SMB_SLV    = 3'b101,
      SMB_RSTART = 3'b110
   } smb_st_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } smb_sfr_req_t;

   typedef struct packed {
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } smb_pin_out_t;

   typedef struct packed {
      smb_st_t    st;
      logic       master;
      logic       transmit_direction_flag;
      logic       start_request_flag;
      logic       stop_request_flag;
      logic       ack_needed_flag;
      logic       arbitration_lost_flag;
      logic       ack;
      logic       si;
      logic       ena;
      logic       inh;
      logic       busy;
      logic       ignore;
      logic       addr_ph;
      logic       dat_wr;
      logic [7:0] dat;
      logic [3:0] bitn;
      logic [15:0] cnt;
      logic       scl_oe;
      logic       sda_oe;
      logic [1:0] scl_sy;
      logic [1:0] sda_sy;
      logic       scl_d;
      logic       sda_d;
      logic [7:0] rdata;
   } smb_state_t;
endpackage

// ---- sim/smb_slave_model.sv ----
// behavioural far-side target: takes bytes, acks or refuses them, may stretch the clock
`timescale 1ns/10ps
module smb_slave_model (
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   input  wire logic        i_nack,
   input  wire logic [15:0] i_stretch_ns,
   output logic             o_sda_pull,
   output logic             o_scl_pull,
   output logic             o_byte_ev,
   output logic [7:0]       o_byte,
   output logic             o_stop_ev
);
   logic [7:0] sh;
   int         nb;

   // nothing pulled at power-up: both wires rest at the pull-up level
   initial begin
      o_sda_pull = 1'b0;
      o_scl_pull = 1'b0;
      o_byte_ev  = 1'b0;
      o_byte     = 8'h00;
      o_stop_ev  = 1'b0;
      nb         = 0;
      sh         = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // start restarts the bit count, stop gives a short event pulse
   always @(negedge i_sda) if (i_scl === 1'b1) nb = 0;
   always @(posedge i_sda) begin
      if (i_scl === 1'b1) begin
         o_stop_ev = 1'b1;
         #1 o_stop_ev = 1'b0;
      end
   end

   // data is taken while the clock is high, first bit lands in the top position
   always @(posedge i_scl) begin
      if (nb < 8) begin
         sh = {sh[6:0], i_sda};
         nb++;
      end
   end

   // ack is driven from the falling edge after bit 8 to the falling edge after bit 9; stretching holds the clock after the byte
   always @(negedge i_scl) begin
      if (nb == 8) begin
         nb         = 9;
         o_byte     = sh;
         o_sda_pull = !i_nack;
         o_byte_ev  = 1'b1;
         #1 o_byte_ev = 1'b0;
         if (i_stretch_ns > 16'h0000) begin
            o_scl_pull = 1'b1;
            #(i_stretch_ns) o_scl_pull = 1'b0;
         end
      end else if (nb == 9) begin
         o_sda_pull = 1'b0;
         nb         = 0;
      end
   end
endmodule

// ---- sim/smbus_flag_and_data_control_bench.sv ----
// self-checking bench: master write and read transfers against the behavioural target
`timescale 1ns/10ps
`define CHK(nm, got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
   $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module smbus_flag_and_data_control_bench;
   import smb_pkg::*;
   typedef struct {string nm; logic [7:0] exp; logic [7:0] msk;} smb_note_t;
   logic          i_core_clk, i_rst, i_scl, i_sda, o_irq, rd_d;
   logic          nack, sda_pull, scl_pull, byte_ev, stop_ev;
   logic [7:0]    o_sfr_rdata, got_byte, exp_byte;
   logic [15:0]   stretch_ns;
   logic [31:0]   seed;
   smb_sfr_req_t  i_sfr;
   smb_pin_out_t  o_pins;
   smb_note_t     note;
   smb_note_t     rd_q[$];
   logic [7:0]    bus_q[$];
   int            n_errors, samples_checked, stops;

   // wired-and bus with pull-ups: any party pulling wins
   assign i_scl = ~(o_pins.scl_oe | scl_pull);
   assign i_sda = ~(o_pins.sda_oe | sda_pull);

   // half period of 4 core cycles, plus 2 synchroniser cycles in the high phase, gives the 100 ns link clock
   smb_ctrl #(.HALF_CYC(16'h0004)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_sfr(i_sfr),
      .o_sfr_rdata(o_sfr_rdata), .i_scl(i_scl), .i_sda(i_sda), .o_pins(o_pins), .o_irq(o_irq));
   smb_slave_model tgt (.i_scl(i_scl), .i_sda(i_sda), .i_nack(nack), .i_stretch_ns(stretch_ns),
      .o_sda_pull(sda_pull), .o_scl_pull(scl_pull), .o_byte_ev(byte_ev), .o_byte(got_byte),
      .o_stop_ev(stop_ev));

   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // xorshift keeps the random bytes repeatable from one run to the next
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // strobes are held one cycle then idle one cycle, so no two writes share a time step
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
      i_sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(negedge i_core_clk);
      i_sfr.wr = 1'b0;
      @(negedge i_core_clk);
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
                         input string nm);
      rd_q.push_back('{nm, e, m});
      i_sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge i_core_clk);
      i_sfr.rd = 1'b0;
      @(negedge i_core_clk);
   endtask

   task automatic wait_irq(input logic lvl);
      for (int k = 0; k < 4000; k++) begin
         if (o_irq === lvl) return;
         @(negedge i_core_clk);
      end
      n_errors++;
      finish_test();
   endtask

   // one byte as master transmitter, loaded while the interrupt flag is set
   task automatic send_byte(input logic [7:0] v, input logic [7:0] ctl);
      bus_q.push_back(v);
      reg_wr(8'hc2, v);
      reg_wr(8'hc0, 8'h00);
      wait_irq(1'b0);
      wait_irq(1'b1);
      `CHK("scl held", o_pins.scl_oe, 1'b1)
      reg_rd(8'hc0, ctl, 8'hff, "control after byte");
      reg_rd(8'hc2, v, 8'hff, "data after byte");
      repeat (20) @(negedge i_core_clk);
      reg_rd(8'hc2, v, 8'hff, "data while flag set");
   endtask

   ////////////////////////////////////////////////////////////////////////////////////////
   // read answers are compared one cycle after the strobe, oldest note first
   always @(posedge i_core_clk) rd_d <= i_sfr.rd;
   always @(negedge i_core_clk) begin
      if (rd_d === 1'b1 && rd_q.size() > 0) begin
         note = rd_q.pop_front();
         `CHK(note.nm, o_sfr_rdata & note.msk, note.exp)
      end
   end

   // bytes seen by the target must match what was loaded, in order
   always @(posedge byte_ev) begin
      // the note is taken off once, so a mismatch report cannot pop a second one
      if (bus_q.size() > 0) begin
         exp_byte = bus_q.pop_front();
         `CHK("bus byte", got_byte, exp_byte)
      end
   end
   always @(posedge stop_ev) stops++;

   initial begin
      i_sfr           = '0;
      i_rst           = 1'b1;
      nack            = 1'b0;
      stretch_ns      = 16'h0000;
      n_errors        = 0;
      samples_checked = 0;
      seed            = 32'hcd1325b2;
      repeat (5) @(negedge i_core_clk);
      i_rst = 1'b0;
      stops = 0;
      @(negedge i_core_clk);
      reg_rd(8'hc2, 8'h00, 8'hff, "data reset");
      reg_rd(8'hc0, 8'h00, 8'hff, "control reset");
      reg_wr(8'hc5, 8'hff);
      reg_rd(8'hc5, 8'h00, 8'hff, "unmapped");
      reg_wr(8'hc1, 8'h80);
      reg_wr(8'hc0, 8'h20);
      wait_irq(1'b1);
      reg_rd(8'hc0, 8'he1, 8'hff, "control after start");
      seed = xs(seed);
      send_byte({seed[7:1], 1'b0}, 8'hc3);
      seed       = xs(seed);
      stretch_ns = 16'd300;
      send_byte(seed[15:8], 8'hc3);
      seed       = xs(seed);
      stretch_ns = 16'h0000;
      nack       = 1'b1;
      send_byte(seed[23:16], 8'hc1);
      // no data write before the clear turns the master into a receiver; target stays quiet
      reg_wr(8'hc0, 8'h00);
      wait_irq(1'b0);
      wait_irq(1'b1);
      reg_rd(8'hc0, 8'h89, 8'hff, "control after receive");
      reg_rd(8'hc2, 8'hff, 8'hff, "data received");
      nack = 1'b0;
      // stop request with clearing the flag ends it; ack left 0 sends not-acknowledge
      reg_wr(8'hc0, 8'h10);
      for (int k = 0; k < 2000 && stops == 0; k++) @(negedge i_core_clk);
      `CHK("stop seen", stops, 1)
      repeat (10) @(negedge i_core_clk);
      reg_rd(8'hc0, 8'h00, 8'h98, "control after stop");
      `CHK("sda released", o_pins.sda_oe, 1'b0)
      `CHK("irq low", o_irq, 1'b0)
      `CHK("bytes left", bus_q.size(), 0)
      finish_test();
   end
endmodule
